// [pmrc_pkg.sv]
// Package for the power mode and reset controller
package pmrc_pkg;

  // Register byte fields and reset values
  localparam int CKC_WAKE_BIT  = 6;
  localparam int CKC_RC_WATCHDOG_ENABLE_BIT = 5;
  localparam int CKC_WDT_RESET_SELECT_BIT = 4;
  localparam logic [7:0] CKC_RESET = 8'h00;
  localparam logic [7:0] IEH_RESET = 8'h00;
  localparam int IEH_WDT_IRQ_ENABLE_BIT = 1;
  localparam logic [7:0] PFC_RESET = 8'h00;
  localparam int PFC_DIS_BIT  = 0;
  localparam int PFC_PFS_BIT  = 1;
  localparam int PFC_FLAG_BIT = 2;
  localparam logic [7:0] WDM_RESET = 8'h7F;
  localparam logic [7:0] TP_RESET  = 8'hFF;

  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_CKC  = 4'h0;
  localparam logic [3:0] OFS_IEH  = 4'h4;
  localparam logic [3:0] OFS_PFC  = 4'h8;
  localparam logic [3:0] OFS_WDM  = 4'hC;

  // Timing figures
  localparam int CLK_MHZ        = 200;
  localparam int RST_HOLD_OSC   = 8;
  localparam int STARTUP_MS     = 64;
  localparam int STARTUP_REF_KHZ = 4000;
  localparam int STARTUP_EXTRA  = 7;
  localparam int STARTUP_CYC    = STARTUP_MS * STARTUP_REF_KHZ + STARTUP_EXTRA;
  localparam int PF_GLITCH_NS   = 50;
  localparam int PF_CYC         = (PF_GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int PSC_DIV        = 2048;
  localparam logic [7:0] BIT_OVF = 8'hFF;

  typedef enum logic [2:0] {
    PM_RUN, PM_STOP, PM_RCSTOP, PM_WAKET, PM_STAB, PM_RESET
  } pmrc_mode_e;

  typedef struct packed {
    logic       stop_exec;
    logic       i_flag;
    logic [7:0] wdata;
  } pmrc_cpu_s;

  typedef struct packed {
    logic cpu_halt;
    logic main_osc_en;
    logic rc_osc_en;
    logic timers_run;
    logic vector_wdt;
    logic vector_irq;
    logic resume;
  } pmrc_ctl_s;

  function automatic logic [7:0] pmrc_inc8(input logic [7:0] v);
    pmrc_inc8 = v + 8'h01;
  endfunction : pmrc_inc8

endpackage : pmrc_pkg

// [pmrc_filter.sv]
// Qualifies a level: output rises after input held high for a count, falls on the next edge
`timescale 1ns/100ps
`default_nettype none
module pmrc_filter #(
  parameter int COUNT = 8
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Level in and qualified level out
  input  wire logic level_in,
  output logic      level_out
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        out;
  } pmrc_flt_s;

  pmrc_flt_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (!level_in) begin
      st_d.cnt = 16'h0000;
      st_d.out = 1'b0;
    end else if (st_q.cnt >= 16'(COUNT - 1)) begin
      st_d.out = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.out;
endmodule : pmrc_filter
`default_nettype wire

// [pmrc_wdog.sv]
// Seven-bit watchdog counter on the RC tick with match flag
`timescale 1ns/100ps
`default_nettype none
module pmrc_wdog (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       rc_tick,
  input  wire logic       clear,
  input  wire logic [6:0] match_val,
  // Flag
  output logic            match
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       match;
  } pmrc_wd_s;

  pmrc_wd_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.match = 1'b0;
    if (clear) begin
      st_d.cnt = 7'h00;
    end else if (rc_tick) begin
      if (st_q.cnt == match_val) begin
        st_d.match = 1'b1;
        st_d.cnt   = 7'h00;
      end else begin
        st_d.cnt = st_q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign match = st_q.match;
endmodule : pmrc_wdog
`default_nettype wire

// [pmrc_top.sv]
// Power mode, wake-up and reset controller with Avalon-MM registers
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - RC stop halts main clock, keeps RC
// - STOP with RC enable, wake select clear, enters RC stop
// - RC stop ends on reset or interrupt
// - Wake with watchdog irq runs its handler
// - Wake with reset select resets the chip
// - Flag clear resumes after STOP, no vector
// - Stop wake waits interval timer 00 to FF
// - Wake timer mode keeps oscillator and timers
// - STOP with wake select enters timer mode
// - Timer period from loaded value, two separate timers
// - Timer mode ends on reset, overflow, interrupt
// - Timer mode exit has no stabilisation wait
// - Port pins keep driving during low power
// - Reset pin low eight periods is recognised
// - Start-up waits 64 ms plus seven periods
// - Reset never touches RAM
// - Power-fail detector on when disable bit clear
// - Low supply over 50 ns flags, may reset
// - Watchdog match raises flag, irq or reset
// - Watchdog counts on RC except in plain stop
// - STOP with wake select and RC enable clear: plain stop
module pmrc_top #(
  parameter int STARTUP_CYCLES = pmrc_pkg::STARTUP_CYC,
  parameter int PSC_DIV        = pmrc_pkg::PSC_DIV,
  parameter int TIMER_W        = 16
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Core side
  input  wire pmrc_pkg::pmrc_cpu_s cpu,
  input  wire logic                bit_tick,
  input  wire logic                rc_tick,
  input  wire logic                ext_irq,
  input  wire logic [TIMER_W-1:0]  timer0_period_value,
  input  wire logic [TIMER_W-1:0]  timer2_period_value,
  // Pins and analog
  input  wire logic                reset_pin_n,
  input  wire logic                supply_low,
  // Status and control out
  output pmrc_pkg::pmrc_ctl_s      ctl,
  output pmrc_pkg::pmrc_mode_e     mode,
  output logic                     core_reset,
  output logic                     port_hold
);
  typedef struct packed {
    pmrc_pkg::pmrc_mode_e mode;
    logic [7:0]           ckc;
    logic [7:0]           ieh;
    logic [7:0]           pfc;
    logic [7:0]           wdm;
    logic [31:0]          rdata;
    logic                 ack;
    logic [31:0]          rst_cnt;
    logic [7:0]           bit_cnt;
    logic [11:0]          psc;
    logic [TIMER_W-1:0]   t0;
    logic [TIMER_W-1:0]   t2;
    logic                 wdt_pend;
    logic [2:0]           wake_why;
    pmrc_pkg::pmrc_ctl_s  ctl;
  } pmrc_st_s;

  pmrc_st_s st_q, st_d;

  logic pin_low_q;
  logic pf_low_q;
  logic wd_match;
  logic pf_event;
  logic any_reset;
  logic wake_irq;
  logic stopped;
  logic psc_tick;
  logic hit;

  // Qualified pin reset and power-fail glitch filter
  pmrc_filter #(.COUNT(pmrc_pkg::RST_HOLD_OSC)) u_pin (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .level_in  (!reset_pin_n),
    .level_out (pin_low_q)
  );

  pmrc_filter #(.COUNT(pmrc_pkg::PF_CYC + 1)) u_pf (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .level_in  (supply_low && !st_q.pfc[pmrc_pkg::PFC_DIS_BIT]),
    .level_out (pf_low_q)
  );

  // RC tick drives the counter even while the main clock is gated in RC stop
  pmrc_wdog u_wdog (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .rc_tick   (rc_tick && st_q.ctl.rc_osc_en),
    .clear     (avs_write && !avs_waitrequest && avs_address == pmrc_pkg::OFS_WDM
                && avs_byteenable[0] && avs_writedata[7]),
    .match_val (st_q.wdm[6:0]),
    .match     (wd_match)
  );

  assign pf_event  = pf_low_q && st_q.pfc[pmrc_pkg::PFC_PFS_BIT];
  // Watchdog in reset mode shares the pin reset path
  assign any_reset = pin_low_q || pf_event
                     || (wd_match && st_q.ckc[pmrc_pkg::CKC_WDT_RESET_SELECT_BIT]);
  // Interrupt seen combinationally, no main-clock qualification needed
  assign wake_irq  = ext_irq || wd_match;
  assign stopped   = st_q.mode == pmrc_pkg::PM_STOP || st_q.mode == pmrc_pkg::PM_RCSTOP;
  assign psc_tick  = st_q.psc == 12'(PSC_DIV - 1);
  assign hit       = avs_read || avs_write;

  always_comb begin
    st_d = st_q;
    st_d.ack = hit && !st_q.ack;
    st_d.ctl.vector_wdt = 1'b0;
    st_d.ctl.vector_irq = 1'b0;
    st_d.ctl.resume     = 1'b0;

    // Register access; one wait state per request
    if (avs_write && st_q.ack && avs_byteenable[0]) begin
      unique case (avs_address)
        pmrc_pkg::OFS_CKC: st_d.ckc = avs_writedata[7:0];
        pmrc_pkg::OFS_IEH: st_d.ieh = avs_writedata[7:0];
        pmrc_pkg::OFS_PFC: st_d.pfc[1:0] = avs_writedata[1:0];
        pmrc_pkg::OFS_WDM: st_d.wdm = {1'b0, avs_writedata[6:0]};
        default: ;
      endcase
    end
    if (avs_read && !st_q.ack) begin
      unique case (avs_address)
        pmrc_pkg::OFS_CKC: st_d.rdata = {24'h000000, st_q.ckc};
        pmrc_pkg::OFS_IEH: st_d.rdata = {24'h000000, st_q.ieh};
        pmrc_pkg::OFS_PFC: st_d.rdata = {24'h000000, st_q.pfc};
        pmrc_pkg::OFS_WDM: st_d.rdata = {21'h000000, st_q.mode, st_q.wdm};
        default:           st_d.rdata = 32'h00000000;
      endcase
    end
    // Sticky power-fail flag: set wins over the clear
    if (avs_write && st_q.ack && avs_address == pmrc_pkg::OFS_PFC
        && avs_byteenable[0] && !avs_writedata[pmrc_pkg::PFC_FLAG_BIT]) begin
      st_d.pfc[pmrc_pkg::PFC_FLAG_BIT] = 1'b0;
    end
    if (pf_low_q) begin
      st_d.pfc[pmrc_pkg::PFC_FLAG_BIT] = 1'b1;
    end

    // Prescaler runs at divide 2048 in every mode; timers step only in timer mode
    st_d.psc = psc_tick ? 12'h000 : st_q.psc + 12'h001;
    if (st_q.mode == pmrc_pkg::PM_WAKET && psc_tick) begin
      st_d.t0 = st_q.t0 + TIMER_W'(1);
      st_d.t2 = st_q.t2 + TIMER_W'(1);
    end

    unique case (st_q.mode)
      pmrc_pkg::PM_RUN: begin
        if (cpu.stop_exec) begin
          st_d.t0 = '0;
          st_d.t2 = '0;
          if (st_q.ckc[pmrc_pkg::CKC_WAKE_BIT]) begin
            st_d.mode = pmrc_pkg::PM_WAKET;
          end else if (st_q.ckc[pmrc_pkg::CKC_RC_WATCHDOG_ENABLE_BIT]) begin
            st_d.mode = pmrc_pkg::PM_RCSTOP;
          end else begin
            st_d.mode = pmrc_pkg::PM_STOP;
          end
        end
      end
      pmrc_pkg::PM_STOP, pmrc_pkg::PM_RCSTOP: begin
        if (wake_irq) begin
          st_d.mode     = pmrc_pkg::PM_STAB;
          st_d.bit_cnt  = 8'h00;
          st_d.wdt_pend = wd_match;
        end
      end
      pmrc_pkg::PM_WAKET: begin
        // Period equals the loaded value, 16 bits per timer
        if (st_q.t0 == timer0_period_value || st_q.t2 == timer2_period_value
            || ext_irq || wd_match) begin
          st_d.mode     = pmrc_pkg::PM_RUN;
          st_d.wdt_pend = wd_match;
          st_d.wake_why = 3'h1;
        end
      end
      pmrc_pkg::PM_STAB: begin
        if (bit_tick) begin
          st_d.bit_cnt = pmrc_pkg::pmrc_inc8(st_q.bit_cnt);
          if (st_q.bit_cnt == pmrc_pkg::BIT_OVF) begin
            st_d.mode     = pmrc_pkg::PM_RUN;
            st_d.wake_why = 3'h1;
          end
        end
      end
      pmrc_pkg::PM_RESET: begin
        if (st_q.rst_cnt >= 32'(STARTUP_CYCLES - 1)) begin
          st_d.mode = pmrc_pkg::PM_RUN;
        end else begin
          st_d.rst_cnt = st_q.rst_cnt + 32'h00000001;
        end
      end
      default: st_d.mode = pmrc_pkg::PM_RESET;
    endcase

    // Dispatch after a wake completes
    if (st_q.wake_why != 3'h0) begin
      st_d.wake_why = 3'h0;
      if (!cpu.i_flag) begin
        st_d.ctl.resume = 1'b1;
      end else if (st_q.wdt_pend && !st_q.ckc[pmrc_pkg::CKC_WDT_RESET_SELECT_BIT]
                   && st_q.ieh[pmrc_pkg::IEH_WDT_IRQ_ENABLE_BIT]) begin
        st_d.ctl.vector_wdt = 1'b1;
      end else begin
        st_d.ctl.vector_irq = 1'b1;
      end
      st_d.wdt_pend = 1'b0;
    end

    // Any reset source restarts the start-up count; RAM is outside
    if (any_reset || (st_q.wdt_pend && cpu.i_flag
        && st_q.ckc[pmrc_pkg::CKC_WDT_RESET_SELECT_BIT])) begin
      st_d.mode     = pmrc_pkg::PM_RESET;
      st_d.rst_cnt  = 32'h00000000;
      st_d.ckc      = pmrc_pkg::CKC_RESET;
      st_d.ieh      = pmrc_pkg::IEH_RESET;
      st_d.wdm      = pmrc_pkg::WDM_RESET;
      st_d.pfc[1:0] = pmrc_pkg::PFC_RESET[1:0];
      st_d.wdt_pend = 1'b0;
      st_d.wake_why = 3'h0;
    end

    st_d.ctl.cpu_halt    = st_d.mode != pmrc_pkg::PM_RUN;
    st_d.ctl.main_osc_en = !(st_d.mode == pmrc_pkg::PM_STOP
                             || st_d.mode == pmrc_pkg::PM_RCSTOP);
    st_d.ctl.rc_osc_en   = st_d.mode != pmrc_pkg::PM_STOP;
    st_d.ctl.timers_run  = st_d.mode == pmrc_pkg::PM_WAKET;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.mode     <= pmrc_pkg::PM_RESET;
      st_q.wdm      <= pmrc_pkg::WDM_RESET;
      st_q.ctl.cpu_halt    <= 1'b1;
      st_q.ctl.main_osc_en <= 1'b1;
      st_q.ctl.rc_osc_en   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = hit && !st_q.ack;
  assign avs_readdata    = st_q.rdata;
  assign ctl             = st_q.ctl;
  assign mode            = st_q.mode;
  assign core_reset      = st_q.mode == pmrc_pkg::PM_RESET;
  // Ports keep their latched levels while low power holds the core
  assign port_hold       = stopped || st_q.mode == pmrc_pkg::PM_WAKET;
endmodule : pmrc_top
`default_nettype wire

// [pmrc_chk.sv]
// Concurrent checks on the power mode and reset controller ports
`timescale 1ns/100ps
`default_nettype none
module pmrc_chk (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // Watched ports
  input wire pmrc_pkg::pmrc_cpu_s  cpu,
  input wire logic                 bit_tick,
  input wire logic                 ext_irq,
  input wire logic                 reset_pin_n,
  input wire pmrc_pkg::pmrc_ctl_s  ctl,
  input wire pmrc_pkg::pmrc_mode_e mode,
  input wire logic                 port_hold
);
  // Interval ticks seen while stabilising
  logic [8:0] tk_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tk_q <= 9'h000;
    else if (mode != pmrc_pkg::PM_STAB) tk_q <= 9'h000;
    else if (bit_tick) tk_q <= tk_q + 9'h001;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_hold_pins:
    assert property ((mode inside {pmrc_pkg::PM_STOP, pmrc_pkg::PM_RCSTOP,
      pmrc_pkg::PM_WAKET}) [*2] |-> port_hold) else $error("port hold low in sleep");
  a_rc_clocks:
    assert property (mode == pmrc_pkg::PM_RCSTOP [*2] |-> !ctl.main_osc_en && ctl.rc_osc_en)
    else $error("clock enables wrong in rc stop");
  a_wake_clocks:
    assert property (mode == pmrc_pkg::PM_WAKET [*2] |-> ctl.main_osc_en && ctl.timers_run)
    else $error("clock enables wrong in timer mode");
  a_stop_entry:
    assert property (mode == pmrc_pkg::PM_RUN && cpu.stop_exec |=> mode inside
      {pmrc_pkg::PM_STOP, pmrc_pkg::PM_RCSTOP, pmrc_pkg::PM_WAKET})
    else $error("stop not entered");
  a_no_stab:
    assert property (mode == pmrc_pkg::PM_WAKET |=> mode != pmrc_pkg::PM_STAB)
    else $error("timer mode exit waited");
  a_pin_reset:
    assert property (!reset_pin_n [*8] |-> ##[0:3] mode == pmrc_pkg::PM_RESET)
    else $error("long pin low not taken");
  a_stab_ticks:
    assert property ($past(mode) == pmrc_pkg::PM_STAB && mode == pmrc_pkg::PM_RUN
      |-> tk_q >= 9'h0FF && tk_q <= 9'h100) else $error("stabilise count wrong");
  a_resume:
    assert property ($past(mode) == pmrc_pkg::PM_STAB && mode == pmrc_pkg::PM_RUN
      && !cpu.i_flag |-> ##[0:1] ctl.resume) else $error("no resume pulse");
  a_stop_wake:
    assert property (mode inside {pmrc_pkg::PM_STOP, pmrc_pkg::PM_RCSTOP} && ext_irq
      |-> ##[1:2] mode == pmrc_pkg::PM_STAB) else $error("irq did not wake");
  a_timer_exit:
    assert property (mode == pmrc_pkg::PM_WAKET && ext_irq |-> ##[1:2] mode == pmrc_pkg::PM_RUN)
    else $error("irq did not end timer mode");
endmodule : pmrc_chk
bind pmrc_top pmrc_chk chk_u (.mclk(mclk), .rst_n(rst_n), .cpu(cpu), .bit_tick(bit_tick),
  .ext_irq(ext_irq), .reset_pin_n(reset_pin_n), .ctl(ctl), .mode(mode), .port_hold(port_hold));
`default_nettype wire

// [pmrc_partner.sv]
// Model of reset pin, interrupt pin and tick sources
`timescale 1ns/100ps
`default_nettype none
module pmrc_partner (
  // Clock and bench commands
  input  wire logic       mclk,
  input  wire logic       pin_go,
  input  wire logic [3:0] pin_len,
  input  wire logic       irq_go,
  input  wire logic       rc_on,
  // Toward the controller
  output logic            reset_pin_n,
  output logic            ext_irq,
  output logic            bit_tick,
  output logic            rc_tick
);
  logic [3:0] pin_q = 4'h0;
  logic [2:0] irq_q = 3'h0;
  logic [2:0] div_q = 3'h0;
  always @(posedge mclk) begin
    div_q <= div_q + 3'h1;
    pin_q <= pin_go ? pin_len : (pin_q != 4'h0) ? pin_q - 4'h1 : 4'h0;
    irq_q <= irq_go ? 3'h4 : (irq_q != 3'h0) ? irq_q - 3'h1 : 3'h0;
  end
  // Pin stays low for the whole commanded span
  assign reset_pin_n = (pin_q == 4'h0);
  assign ext_irq     = (irq_q != 3'h0);
  // Scaled interval tick keeps run time short
  assign bit_tick    = div_q[0];
  assign rc_tick     = rc_on && (div_q[1:0] == 2'h3);
endmodule : pmrc_partner
`default_nettype wire

// [pmrc_tb.sv]
// Self-checking bench for the power mode and reset controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                 mclk = 1'b0;
  logic                 rst_n = 1'b0;
  logic [3:0]           adr = 4'h0;
  logic                 rd = 1'b0;
  logic                 wr = 1'b0;
  logic [7:0]           wd = 8'h00;
  logic [31:0]          rdata;
  logic                 wreq;
  pmrc_pkg::pmrc_cpu_s  cpu = '0;
  pmrc_pkg::pmrc_ctl_s  ctl;
  pmrc_pkg::pmrc_mode_e mode;
  logic                 bit_tick, rc_tick, ext_irq, pin_n, core_reset, port_hold;
  logic [15:0]          t0p = 16'hFFFF;
  logic [15:0]          t2p = 16'hFFFF;
  logic                 low = 1'b0;
  logic                 pin_go = 1'b0;
  logic [3:0]           pin_len = 4'h0;
  logic                 irq_go = 1'b0;
  logic                 rc_on = 1'b0;
  logic [2:0]           seen = 3'h0;
  logic [31:0]          seed = 32'h216B;
  logic [7:0]           r;
  int                   mismatches = 0;
  int                   checks_done = 0;
  int                   n;
  localparam logic [3:0] RA [5] = '{pmrc_pkg::OFS_CKC, pmrc_pkg::OFS_IEH, pmrc_pkg::OFS_PFC,
                                    pmrc_pkg::OFS_WDM, 4'h2};
  localparam logic [7:0] RV [5] = '{pmrc_pkg::CKC_RESET, pmrc_pkg::IEH_RESET,
                                    pmrc_pkg::PFC_RESET, pmrc_pkg::WDM_RESET, 8'h00};
  localparam logic [7:0] CK [5] = '{8'h00, 8'h20, 8'h20, 8'h20, 8'h30};
  localparam logic [4:0] IFL = 5'h16;
  localparam logic [4:0] WDW = 5'h1C;
  localparam logic [2:0] PX [5] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h0};
  localparam logic [7:0] PFW [4] = '{8'h00, 8'h00, 8'h01, 8'h02};
  localparam int         PFL [4] = '{9, 12, 12, 12};
  localparam logic [7:0] PFR [4] = '{8'h00, 8'h04, 8'h01, 8'h00};

  always #2.5 mclk = ~mclk;
  always @(negedge mclk) seen <= seen | {ctl.vector_wdt, ctl.vector_irq, ctl.resume};

  // Prescaler scaled down from its full division
  pmrc_top #(.STARTUP_CYCLES(20), .PSC_DIV(4), .TIMER_W(16)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata({24'h000000, wd}), .avs_byteenable(4'h1), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .cpu(cpu), .bit_tick(bit_tick), .rc_tick(rc_tick),
    .ext_irq(ext_irq), .timer0_period_value(t0p), .timer2_period_value(t2p),
    .reset_pin_n(pin_n), .supply_low(low), .ctl(ctl), .mode(mode),
    .core_reset(core_reset), .port_hold(port_hold));
  pmrc_partner far_u (.mclk(mclk), .pin_go(pin_go), .pin_len(pin_len), .irq_go(irq_go),
    .rc_on(rc_on), .reset_pin_n(pin_n), .ext_irq(ext_irq), .bit_tick(bit_tick),
    .rc_tick(rc_tick));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic pmrc_pkg::pmrc_mode_e exp_mode(input logic [7:0] ck);
    if (ck[pmrc_pkg::CKC_WAKE_BIT]) return pmrc_pkg::PM_WAKET;
    if (ck[pmrc_pkg::CKC_RC_WATCHDOG_ENABLE_BIT]) return pmrc_pkg::PM_RCSTOP;
    return pmrc_pkg::PM_STOP;
  endfunction : exp_mode
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Whole-byte access; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    if (k >= 20) begin
      chk("bus wait", 0, 1);
      give_verdict();
    end
    // Read data taken at the same edge that ends the wait
    r = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic wait_mode(input pmrc_pkg::pmrc_mode_e m, input int lim);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (mode !== m && n < lim);
    chk("mode", 32'(m), 32'(mode));
    if (mode !== m) give_verdict();
    @(posedge mclk);
  endtask : wait_mode
  task automatic sleep(input logic [7:0] ck, input logic fl);
    bus(1'b1, pmrc_pkg::OFS_CKC, ck);
    cpu.i_flag    <= fl;
    cpu.stop_exec <= 1'b1;
    @(posedge mclk);
    cpu.stop_exec <= 1'b0;
    seen = 3'h0;
    wait_mode(exp_mode(ck), 3);
  endtask : sleep

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wait_mode(pmrc_pkg::PM_RUN, 40);
    chk("startup", 1, 32'(n >= 20 && n <= 22));
    bus(1'b1, 4'h2, 8'hA5);
    foreach (RA[i]) begin
      bus(1'b0, RA[i], 8'h00);
      chk("reg reset", RV[i], r);
    end
    bus(1'b1, pmrc_pkg::OFS_IEH, 8'h02);
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      bus(1'b1, pmrc_pkg::OFS_WDM, {5'h10, seed[2:0] | 3'h1});
      sleep(CK[i], IFL[i]);
      rc_on  <= WDW[i];
      irq_go <= !WDW[i];
      @(posedge mclk);
      irq_go <= 1'b0;
      if (i == 4) begin
        wait_mode(pmrc_pkg::PM_RESET, 600);
        rc_on <= 1'b0;
        wait_mode(pmrc_pkg::PM_RUN, 40);
        bus(1'b0, pmrc_pkg::OFS_CKC, 8'h00);
        chk("ckc after reset", 8'h00, r);
      end else begin
        wait_mode(pmrc_pkg::PM_STAB, 60);
        rc_on <= 1'b0;
        wait_mode(pmrc_pkg::PM_RUN, 600);
        repeat (3) @(posedge mclk);
        chk("wake pulse", PX[i], seen);
        bus(1'b0, pmrc_pkg::OFS_CKC, 8'h00);
        chk("ckc kept", CK[i], r);
      end
    end
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      t0p <= (k == 0) ? {13'h0000, seed[2:0]} + 16'h0001 : 16'hFFFF;
      t2p <= (k == 1) ? {13'h0000, seed[2:0]} + 16'h0001 : 16'hFFFF;
      sleep({2'h1, seed[3], 5'h00}, seed[4]);
      irq_go <= (k == 2);
      wait_mode(pmrc_pkg::PM_RUN, 4 * int'(seed[2:0]) + 12);
      irq_go <= 1'b0;
    end
    for (int j = 7; j < 9; j++) begin
      pin_len <= 4'(j);
      pin_go  <= 1'b1;
      @(posedge mclk);
      pin_go  <= 1'b0;
      repeat (12) @(negedge mclk);
      chk("pin reset", 32'(j == 8), 32'(mode === pmrc_pkg::PM_RESET));
      @(posedge mclk);
      if (j == 8) wait_mode(pmrc_pkg::PM_RUN, 40);
    end
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, pmrc_pkg::OFS_PFC, PFW[j]);
      low <= 1'b1;
      repeat (PFL[j]) @(posedge mclk);
      low <= 1'b0;
      if (j == 3) begin
        wait_mode(pmrc_pkg::PM_RESET, 4);
        wait_mode(pmrc_pkg::PM_RUN, 40);
      end else begin
        wait_mode(pmrc_pkg::PM_RUN, 2);
      end
      bus(1'b0, pmrc_pkg::OFS_PFC, 8'h00);
      chk("power fail", PFR[j], r & ((j == 3) ? 8'h03 : 8'hFF));
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
